//--- bench/tcc_cpu_model.sv
`timescale 1ns/1ps

// --------------------
// processor side of the byte port
// --------------------
module tcc_cpu_model
	import tcc_pkg::*;
(
	input  wire logic       clk_sys,
	output logic [7:0]      busAddr,
	output logic            busWr,
	output logic            busRd,
	output logic [7:0]      busWdata,
	input  wire logic [7:0] busRdata
);
	initial
	begin
		busAddr  = 8'h00;
		busWr    = 1'b0;
		busRd    = 1'b0;
		busWdata = 8'h00;
	end

	// no interrupts live here, so a byte pair is never split
	task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
		@(posedge clk_sys);
		#1;
		busAddr  = adr;
		busWdata = dat;
		busWr    = 1'b1;
		@(posedge clk_sys);
		#1;
		busWr    = 1'b0;
	endtask

	task automatic rd(input logic [7:0] adr, output logic [7:0] dat);
		@(posedge clk_sys);
		#1;
		busAddr = adr;
		busRd   = 1'b1;
		@(posedge clk_sys);
		#1;
		busRd   = 1'b0;
		dat     = busRdata;
	endtask

	// upper byte first on writes, lower byte first on reads
	task automatic wr16(input logic [7:0] adr, input logic [15:0] val);
		wr(adr + 8'h01, val[15:8]);
		wr(adr, val[7:0]);
	endtask

	task automatic rd16(input logic [7:0] adr, output logic [15:0] val);
		rd(adr, val[7:0]);
		rd(adr + 8'h01, val[15:8]);
	endtask
endmodule

//--- bench/tcc_timer16_test.sv
`timescale 1ns/1ps

module tcc_timer16_test
	import tcc_pkg::*;
	;
	logic        clk_sys       = 1'b0;
	logic        rst_n         = 1'b0;
	logic        ce            = 1'b1;
	logic        extCountPin   = 1'b0;
	logic        capturePin    = 1'b0;
	logic        comparatorOut = 1'b0;
	logic        captAck       = 1'b0;
	logic        ovfAck        = 1'b0;
	logic [15:0] compareTop    = 16'h0100;
	wire  [7:0]  busAddr;
	wire  [7:0]  busWdata;
	wire  [7:0]  busRdata;
	wire         busWr;
	wire         busRd;
	wire         captIrq;
	wire         ovfIrq;
	wire         atMax;
	wire         atBottom;
	wire         countDown;
	int          mismatches    = 0;
	int          checks        = 0;
	int          n;
	int          n1;
	int          n2;
	logic [7:0]  b;
	logic [15:0] w;

	always #5 clk_sys = ~clk_sys;

	tcc_cpu_model cpu (.clk_sys(clk_sys), .busAddr(busAddr), .busWr(busWr), .busRd(busRd),
		.busWdata(busWdata), .busRdata(busRdata));

	tcc_timer16 uut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .busAddr(busAddr), .busWr(busWr),
		.busRd(busRd), .busWdata(busWdata), .busRdata(busRdata), .extCountPin(extCountPin),
		.capturePin(capturePin), .comparatorOut(comparatorOut), .compareTop(compareTop),
		.captAck(captAck), .ovfAck(ovfAck), .captIrq(captIrq), .ovfIrq(ovfIrq), .atMax(atMax),
		.atBottom(atBottom), .countDown(countDown));

	// --------------------
	// shared helpers
	// --------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask

	function automatic logic sig(input int sel);
		case (sel)
			0:       return captIrq;
			1:       return ovfIrq;
			2:       return atMax;
			3:       return countDown;
			default: return atBottom;
		endcase
	endfunction

	// bounded wait; a hang here is reported instead of stalling the run
	task automatic waitHi(input int sel, input int lim, output int cnt);
		cnt = 0;
		while (sig(sel) !== 1'b1 && cnt < lim)
		begin
			cyc(1);
			cnt++;
		end
		check("wait for event", 16'(sig(sel)), 16'h0001);
	endtask

	// --------------------
	// scenarios
	// --------------------
	task automatic tResetValues();
		cpu.rd(OFS_CTRL_B, b);
		check("ctrl b", 16'(b), 16'(RST_BYTE));
		cpu.rd(OFS_FLAGS, b);
		check("flags", 16'(b), 16'(RST_BYTE));
		check("outputs", {11'h000, atBottom, atMax, countDown, captIrq, ovfIrq}, 16'h0010);
		cpu.rd(8'h3f, b);
		check("unmapped", 16'(b), 16'h0000);
		cpu.wr(OFS_MASK, 8'h21);
	endtask

	task automatic tStopAndLatch();
		cpu.wr16(OFS_COUNT_LO, 16'h01ff);
		cyc(20);
		cpu.rd16(OFS_COUNT_LO, w);
		check("stopped count", w, 16'h01ff);
		cpu.wr(OFS_COUNT_HI, 8'h77);
		cpu.rd(OFS_COUNT_HI, b);
		check("latch", 16'(b), 16'h0077);
		cpu.rd16(OFS_COUNT_LO, w);
		check("count after lone high", w, 16'h01ff);
	endtask

	task automatic tExtCount();
		cpu.wr16(OFS_COUNT_LO, 16'h0010);
		for (int cs = 6; cs < 8; cs++)
		begin
			cpu.wr(OFS_CTRL_B, 8'(cs));
			repeat (3)
			begin
				extCountPin = 1'b1;
				cyc(4);
				extCountPin = 1'b0;
				cyc(4);
			end
		end
		cpu.wr(OFS_CTRL_B, 8'h00);
		cpu.rd16(OFS_COUNT_LO, w);
		check("external count", w, 16'h0016);
	endtask

	task automatic tSingleSlope();
		cpu.wr16(OFS_COUNT_LO, 16'hfffd);
		cpu.wr(OFS_CTRL_B, 8'h01);
		waitHi(2, 10, n);
		waitHi(4, 5, n);
		waitHi(1, 3, n);
		cpu.wr16(OFS_COUNT_LO, 16'h1000);
		cpu.wr(OFS_CTRL_B, 8'h00);
		cpu.rd16(OFS_COUNT_LO, w);
		check("write beats tick", w, 16'h1002);
		cpu.wr(OFS_FLAGS, 8'h01);
		check("overflow cleared", 16'(ovfIrq), 16'h0000);
	endtask

	task automatic tDualSlope();
		cpu.wr(OFS_CTRL_A, 8'h01);
		cpu.wr16(OFS_COUNT_LO, 16'h00fd);
		cpu.wr(OFS_CTRL_B, 8'h01);
		waitHi(3, 10, n);
		waitHi(4, 600, n);
		waitHi(1, 5, n);
		cpu.wr(OFS_CTRL_B, 8'h00);
		ovfAck = 1'b1;
		cyc(1);
		ovfAck = 1'b0;
		check("overflow acked", 16'(ovfIrq), 16'h0000);
		cpu.wr(OFS_CTRL_A, 8'h00);
	endtask

	task automatic tCapture();
		cpu.wr16(OFS_COUNT_LO, 16'h2345);
		cpu.wr(OFS_CTRL_B, 8'h40);
		capturePin = 1'b1;
		waitHi(0, 10, n1);
		cpu.rd16(OFS_CAPT_LO, w);
		check("captured", w, 16'h2345);
		cpu.wr(OFS_FLAGS, 8'h20);
		check("flag write one", 16'(captIrq), 16'h0000);
		capturePin = 1'b0;
		cyc(10);
		check("wrong edge", 16'(captIrq), 16'h0000);
		cpu.wr(OFS_CTRL_B, 8'hc0);
		capturePin = 1'b1;
		cyc(2);
		capturePin = 1'b0;
		cyc(12);
		check("short pulse", 16'(captIrq), 16'h0000);
		capturePin = 1'b1;
		waitHi(0, 20, n2);
		check("filter delay", 16'(n2 - n1), 16'h0004);
		captAck = 1'b1;
		cyc(1);
		captAck = 1'b0;
		check("flag serviced", 16'(captIrq), 16'h0000);
	endtask

	task automatic tComparator();
		cpu.wr(OFS_CTRL_B, 8'h40);
		cpu.wr16(OFS_COUNT_LO, 16'h0abc);
		cpu.wr(OFS_CMP_CTRL, 8'h04);
		cyc(8);
		cpu.wr(OFS_FLAGS, 8'h20);
		comparatorOut = 1'b1;
		waitHi(0, 10, n);
		cpu.rd16(OFS_CAPT_LO, w);
		check("comparator capture", w, 16'h0abc);
		cpu.wr(OFS_FLAGS, 8'h20);
		capturePin = 1'b0;
		cyc(8);
		capturePin = 1'b1;
		cyc(8);
		check("pin ignored", 16'(captIrq), 16'h0000);
		cpu.wr(OFS_CMP_CTRL, 8'h00);
		cyc(8);
		cpu.wr(OFS_FLAGS, 8'h20);
	endtask

	task automatic tCaptureTop();
		cpu.wr(OFS_CTRL_B, 8'h18);
		cpu.wr16(OFS_CAPT_LO, 16'h0210);
		cpu.wr(OFS_COUNT_LO, 8'h05);
		cpu.rd16(OFS_COUNT_LO, w);
		check("shared high byte", w, 16'h0205);
		cpu.rd16(OFS_CAPT_LO, w);
		check("capture as top", w, 16'h0210);
		capturePin = 1'b0;
		cyc(8);
		check("detector off", 16'(captIrq), 16'h0000);
		cpu.wr(OFS_CTRL_B, 8'h00);
		cpu.wr16(OFS_CAPT_LO, 16'haabb);
		cpu.rd16(OFS_CAPT_LO, w);
		check("capture locked", w, 16'h0210);
	endtask

	// --------------------
	// main sequence and watchdog
	// --------------------
	initial
	begin
		repeat (12) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		tResetValues();
		tStopAndLatch();
		tExtCount();
		tSingleSlope();
		tDualSlope();
		tCapture();
		tComparator();
		tCaptureTop();
		print_verdict();
	end

	// the whole run needs well under a thousand cycles; this allows twenty thousand
	initial
	begin
		#200000;
		mismatches++;
		print_verdict();
	end
endmodule

//--- inc/tcc_pkg.sv
package tcc_pkg;

	// ------------------------------------------------------------
	// register offsets on the 8-bit processor port
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL_A     = 8'h00;
	localparam logic [7:0] OFS_CTRL_B     = 8'h01;
	localparam logic [7:0] OFS_COUNT_LO   = 8'h04;
	localparam logic [7:0] OFS_COUNT_HI   = 8'h05;
	localparam logic [7:0] OFS_CAPT_LO    = 8'h06;
	localparam logic [7:0] OFS_CAPT_HI    = 8'h07;
	localparam logic [7:0] OFS_FLAGS      = 8'h08;
	localparam logic [7:0] OFS_MASK       = 8'h09;
	localparam logic [7:0] OFS_CMP_CTRL   = 8'h0a;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRLB_FILT_BIT  = 7;
	localparam int CTRLB_EDGE_BIT  = 6;
	localparam int CTRLB_WGMH_HI   = 4;
	localparam int CTRLB_WGMH_LO   = 3;
	localparam int CTRLB_CS_HI     = 2;
	localparam int CTRLB_CS_LO     = 0;
	localparam int CTRLA_WGML_HI   = 1;
	localparam int CTRLA_WGML_LO   = 0;
	localparam int FLAG_CAPT_BIT   = 5;
	localparam int FLAG_OVF_BIT    = 0;
	localparam int CMP_SEL_BIT     = 2;

	// ------------------------------------------------------------
	// reset values and counter constants
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [15:0] RST_WORD    = 16'h0000;
	localparam logic [15:0] CNT_MAX     = 16'hffff;
	localparam logic [15:0] CNT_ZERO    = 16'h0000;
	localparam logic [15:0] CNT_ONE     = 16'h0001;
	localparam logic [15:0] TOP_8BIT    = 16'h00ff;
	localparam logic [15:0] TOP_9BIT    = 16'h01ff;
	localparam logic [15:0] TOP_10BIT   = 16'h03ff;
	localparam logic [9:0]  PRE_ONE     = 10'h001;

	// ------------------------------------------------------------
	// clock select codes
	// ------------------------------------------------------------
	localparam logic [2:0] CS_STOP      = 3'h0;
	localparam logic [2:0] CS_DIV1      = 3'h1;
	localparam logic [2:0] CS_DIV8      = 3'h2;
	localparam logic [2:0] CS_DIV64     = 3'h3;
	localparam logic [2:0] CS_DIV256    = 3'h4;
	localparam logic [2:0] CS_DIV1024   = 3'h5;
	localparam logic [2:0] CS_EXT_FALL  = 3'h6;
	localparam logic [2:0] CS_EXT_RISE  = 3'h7;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int FILT_SAMPLES = 4;

endpackage

//--- rtl/tcc_input_filter.sv
`timescale 1ns/1ps

// samples the capture source twice, then optionally filters it
module tcc_input_filter
	import tcc_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic srcAsync,
	input  wire logic filterEn,
	output logic      levelOut
);

	logic                    sync1_r;
	logic                    sync2_r;
	logic [FILT_SAMPLES-2:0] hist_r;
	logic                    filt_r;

	// ------------------------------------------------------------
	// two-flop synchroniser, first stage read only by the second
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
		begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end
		else if (ce)
		begin
			sync1_r <= srcAsync;
			sync2_r <= sync1_r;
		end

	// ------------------------------------------------------------
	// sample history; the synchronised level is the newest sample
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < FILT_SAMPLES-1; gi++)
		begin : g_hist
			always_ff @(posedge clk_sys or negedge rst_n)
				if (!rst_n)
					hist_r[gi] <= 1'b0;
				else if (ce)
					hist_r[gi] <= (gi == 0) ? sync2_r : hist_r[(gi == 0) ? 0 : gi-1];
		end
	endgenerate

	// output only moves when every sample agrees
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			filt_r <= 1'b0;
		else if (ce && (&{hist_r, sync2_r}))
			filt_r <= 1'b1;
		else if (ce && !(|{hist_r, sync2_r}))
			filt_r <= 1'b0;

	// filter on the system clock, so prescaler does not slow it
	assign levelOut = filterEn ? filt_r : sync2_r;

endmodule

//--- rtl/tcc_timer16.sv
`timescale 1ns/1ps

// Functional notes
// - timer ticks from prescaled clock or external pin, chosen by clock select
// - sixteen-bit up/down counter stepping exactly one per tick
// - clear forces zero; separate max and zero indications
// - count seen as two bytes; upper location goes to the shared latch
// - low read copies upper byte to latch; low write loads all sixteen
// - clock select zero stops counting; processor access still works
// - processor count write beats clear and count in the same cycle
// - four-bit waveform mode split across control registers A and B
// - overflow flag set where the waveform mode defines; may interrupt
// - matching edge on pin or comparator copies count to capture
// - capture flag set in the same cycle as the copy
// - capture flag interrupts when enabled; cleared by service or writing one
// - capture read low first copies upper byte into shared latch
// - capture writable only in modes using it as top, upper byte first
// - comparator select bit switches trigger source; switching may capture
// - capture inputs sampled like count pin; filter adds four cycles
// - edge detector off only in capture-as-top modes; filter still follows its enable bit
// - filter output changes only after four agreeing samples
// - filter enable bit in control register B; runs on system clock
module tcc_timer16
	import tcc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic [7:0]  busAddr,
	input  wire logic        busWr,
	input  wire logic        busRd,
	input  wire logic [7:0]  busWdata,
	output logic [7:0]       busRdata,
	input  wire logic        extCountPin,
	input  wire logic        capturePin,
	input  wire logic        comparatorOut,
	input  wire logic [15:0] compareTop,
	input  wire logic        captAck,
	input  wire logic        ovfAck,
	output logic             captIrq,
	output logic             ovfIrq,
	output logic             atMax,
	output logic             atBottom,
	output logic             countDown
);

	logic [7:0]  ctrlA_r;
	logic [7:0]  ctrlB_r;
	logic [7:0]  mask_r;
	logic [7:0]  cmpCtrl_r;
	logic [7:0]  temp_r;
	logic [15:0] count_r;
	logic [15:0] capt_r;
	logic        dir_r;
	logic        captFlag_r;
	logic        ovfFlag_r;
	logic [7:0]  rdata_r;
	logic [9:0]  pre_r;
	logic        ext1_r;
	logic        ext2_r;
	logic        ext3_r;
	logic        capPrev_r;

	logic [3:0]  wgm;
	logic [2:0]  clkSel;
	logic        icrTop;
	logic        ocrTop;
	logic        dual;
	logic [15:0] top;
	logic        tick;
	logic        wrCntLo;
	logic        wrCapLo;
	logic        capLevel;
	logic        capEdge;
	logic        capEvent;
	logic [15:0] countNxt;
	logic        dirNxt;
	logic        ovfHit;
	logic        clrCapt;
	logic        clrOvf;

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	assign wgm     = {ctrlB_r[CTRLB_WGMH_HI:CTRLB_WGMH_LO], ctrlA_r[CTRLA_WGML_HI:CTRLA_WGML_LO]};
	assign clkSel  = ctrlB_r[CTRLB_CS_HI:CTRLB_CS_LO];
	assign icrTop  = (wgm == 4'h8) || (wgm == 4'ha) || (wgm == 4'hc) || (wgm == 4'he);
	assign ocrTop  = (wgm == 4'h4) || (wgm == 4'h9) || (wgm == 4'hb) || (wgm == 4'hf);
	assign dual    = (wgm == 4'h1) || (wgm == 4'h2) || (wgm == 4'h3) || (wgm >= 4'h8 && wgm <= 4'hb);
	assign wrCntLo = busWr && (busAddr == OFS_COUNT_LO);
	assign wrCapLo = busWr && (busAddr == OFS_CAPT_LO) && icrTop;

	always_comb
	begin
		top = CNT_MAX;
		case (wgm)
			4'h1, 4'h5: top = TOP_8BIT;
			4'h2, 4'h6: top = TOP_9BIT;
			4'h3, 4'h7: top = TOP_10BIT;
			4'h8, 4'ha, 4'hc, 4'he: top = capt_r;
			4'h4, 4'h9, 4'hb, 4'hf: top = compareTop;
			default:    top = CNT_MAX;
		endcase
	end

	// ------------------------------------------------------------
	// clock source: prescaler taps and synchronised external pin
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			pre_r <= 10'h000;
		else if (ce && clkSel != CS_STOP)
			pre_r <= pre_r + PRE_ONE;

	// external pin: third flop feeds the edge detector, never the first
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			{ext3_r, ext2_r, ext1_r} <= 3'h0;
		else if (ce)
			{ext3_r, ext2_r, ext1_r} <= {ext2_r, ext1_r, extCountPin};

	always_comb
	begin
		tick = 1'b0;
		case (clkSel)
			CS_STOP:     tick = 1'b0;
			CS_DIV1:     tick = 1'b1;
			CS_DIV8:     tick = &pre_r[2:0];
			CS_DIV64:    tick = &pre_r[5:0];
			CS_DIV256:   tick = &pre_r[7:0];
			CS_DIV1024:  tick = &pre_r;
			CS_EXT_FALL: tick = ext3_r && !ext2_r;
			CS_EXT_RISE: tick = !ext3_r && ext2_r;
			default:     tick = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// counter unit
	// ------------------------------------------------------------
	always_comb
	begin
		countNxt = count_r;
		dirNxt   = dir_r;
		ovfHit   = 1'b0;
		if (dual)
		begin
			if (!dir_r && count_r >= top)
			begin
				dirNxt   = 1'b1;
				countNxt = count_r - CNT_ONE;
			end
			else if (dir_r && count_r == CNT_ZERO)
			begin
				dirNxt   = 1'b0;
				countNxt = count_r + CNT_ONE;
				ovfHit   = 1'b1;
			end
			else
				countNxt = dir_r ? count_r - CNT_ONE : count_r + CNT_ONE;
		end
		else
		begin
			dirNxt = 1'b0;
			if (count_r == top)
			begin
				countNxt = CNT_ZERO;
				ovfHit   = 1'b1;
			end
			else
				countNxt = count_r + CNT_ONE;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
		begin
			count_r <= RST_WORD;
			dir_r   <= 1'b0;
		end
		else if (ce)
		begin
			if (wrCntLo)
				count_r <= {temp_r, busWdata};
			else if (tick)
				count_r <= countNxt;
			if (tick)
				dir_r <= dirNxt;
		end

	assign atMax     = (count_r == CNT_MAX);
	assign atBottom  = (count_r == CNT_ZERO);
	assign countDown = dir_r;

	// ------------------------------------------------------------
	// capture source, filter and edge detector
	// ------------------------------------------------------------
	// the mux sits ahead of the synchroniser, so a source switch can look like an edge
	tcc_input_filter u_filter
	(
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.ce       (ce),
		.srcAsync (cmpCtrl_r[CMP_SEL_BIT] ? comparatorOut : capturePin),
		.filterEn (ctrlB_r[CTRLB_FILT_BIT]),
		.levelOut (capLevel)
	);

	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			capPrev_r <= 1'b0;
		else if (ce)
			capPrev_r <= capLevel;

	assign capEdge  = ctrlB_r[CTRLB_EDGE_BIT] ? (capLevel && !capPrev_r) : (!capLevel && capPrev_r);
	assign capEvent = capEdge && !icrTop;

	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			capt_r <= RST_WORD;
		else if (ce)
		begin
			if (capEvent)
				capt_r <= count_r;
			else if (wrCapLo)
				capt_r <= {temp_r, busWdata};
		end

	// ------------------------------------------------------------
	// flags, set wins over any clear in the same cycle
	// ------------------------------------------------------------
	assign clrCapt = captAck || (busWr && busAddr == OFS_FLAGS && busWdata[FLAG_CAPT_BIT]);
	assign clrOvf  = ovfAck || (busWr && busAddr == OFS_FLAGS && busWdata[FLAG_OVF_BIT]);

	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			captFlag_r <= 1'b0;
		else if (ce)
		begin
			if (capEvent)
				captFlag_r <= 1'b1;
			else if (clrCapt)
				captFlag_r <= 1'b0;
		end

	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			ovfFlag_r <= 1'b0;
		else if (ce)
		begin
			if (tick && ovfHit && !wrCntLo)
				ovfFlag_r <= 1'b1;
			else if (clrOvf)
				ovfFlag_r <= 1'b0;
		end

	assign captIrq = captFlag_r && mask_r[FLAG_CAPT_BIT];
	assign ovfIrq  = ovfFlag_r && mask_r[FLAG_OVF_BIT];

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
		begin
			ctrlA_r   <= RST_BYTE;
			ctrlB_r   <= RST_BYTE;
			mask_r    <= RST_BYTE;
			cmpCtrl_r <= RST_BYTE;
		end
		else if (ce && busWr)
		begin
			case (busAddr)
				OFS_CTRL_A:   ctrlA_r   <= busWdata;
				OFS_CTRL_B:   ctrlB_r   <= busWdata;
				OFS_MASK:     mask_r    <= busWdata;
				OFS_CMP_CTRL: cmpCtrl_r <= busWdata;
				default:      ctrlA_r   <= ctrlA_r;
			endcase
		end

	// ------------------------------------------------------------
	// shared high-byte latch; one latch for both sixteen-bit registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			temp_r <= RST_BYTE;
		else if (ce)
		begin
			if (busWr && (busAddr == OFS_COUNT_HI || busAddr == OFS_CAPT_HI))
				temp_r <= busWdata;
			else if (busRd && busAddr == OFS_COUNT_LO)
				temp_r <= count_r[15:8];
			else if (busRd && busAddr == OFS_CAPT_LO)
				temp_r <= capt_r[15:8];
		end

	// ------------------------------------------------------------
	// read port, answer one cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			rdata_r <= RST_BYTE;
		else if (ce && busRd)
		begin
			case (busAddr)
				OFS_CTRL_A:   rdata_r <= ctrlA_r;
				OFS_CTRL_B:   rdata_r <= ctrlB_r;
				OFS_COUNT_LO: rdata_r <= count_r[7:0];
				OFS_COUNT_HI: rdata_r <= temp_r;
				OFS_CAPT_LO:  rdata_r <= capt_r[7:0];
				OFS_CAPT_HI:  rdata_r <= temp_r;
				OFS_FLAGS:    rdata_r <= {2'h0, captFlag_r, 4'h0, ovfFlag_r};
				OFS_MASK:     rdata_r <= mask_r;
				OFS_CMP_CTRL: rdata_r <= cmpCtrl_r;
				default:      rdata_r <= RST_BYTE;
			endcase
		end

	assign busRdata = rdata_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_write_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && wrCntLo |=> count_r == {$past(temp_r), $past(busWdata)})
		else $error("count write did not load latch and low byte");
	a_stop_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && clkSel == CS_STOP && !wrCntLo |=> $stable(count_r))
		else $error("counter moved with clock stopped");
	a_step_up_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && tick && !wrCntLo && !dual && count_r != top |=> count_r == $past(count_r) + CNT_ONE)
		else $error("counter did not step by one");
	a_clear_at_top: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && tick && !wrCntLo && !dual && count_r == top |=> count_r == CNT_ZERO && ovfFlag_r)
		else $error("counter not cleared with overflow at top");
	a_capture_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && capEvent |=> capt_r == $past(count_r))
		else $error("capture did not copy count");
	a_flag_with_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && capEvent |=> captFlag_r && capt_r == $past(count_r))
		else $error("capture flag not set with copy");
	a_flag_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && clrCapt && !capEvent |=> !captFlag_r)
		else $error("capture flag not cleared");
	a_latch_on_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && busRd && busAddr == OFS_COUNT_LO |=> temp_r == $past(count_r[15:8]))
		else $error("latch not loaded on low count read");
	a_capt_wr_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && busWr && busAddr == OFS_CAPT_LO && !icrTop && !capEvent |=> $stable(capt_r))
		else $error("capture written outside top modes");
	a_no_capt_icrtop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && icrTop && !clrCapt && !captFlag_r |=> !captFlag_r)
		else $error("capture fired in capture-as-top mode");

endmodule
